// >>> rtl/adc_alarm_status_unit.sv
// Alarm collection, mask, summary and calibration status pin routing.
// Alarm sources come from device logic on mclk; register port from the serial decoder.
`timescale 1ns/1ps
// Contract
// - The summary bit is one when any unmasked status flag other than reserved bit 1 is set, else zero.
// - A select input routes the summary bit onto the calibration status pin.
// - Any lane FIFO underflow or overflow sets status bit 5.
// - Each lane keeps its own FIFO error record readable by software.
// - A serializer PLL out of lock sets status bit 4.
// - In 8b/10b modes an enabled link outside its data state sets status bit 3.
// - In 64b/66b modes link start-up and every realignment set status bit 3.
// - A SYSREF clock realignment sets status bit 2.
// - Channel AB dividers differing from CD dividers set status bit 0.
// - A flag stays set until written with one; writing zero leaves it.
// - Reset leaves every alarm flag at one, status reads 0x3f.
// - With the link disabled all flags but the clock alarm are undefined.
// - The mask resets to 0x3f so all sources start excluded.
// - A set mask bit removes the flag in the same position from the summary.
// - Writing one to the FIFO flag also clears every per-lane record bit.
module adc_alarm_status_unit (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input alarm_status_pkg::regReq_type regReq,
  output logic [alarm_status_pkg::DATA_W-1:0] regRdData,
  // Alarm sources
  input alarm_status_pkg::alarmSrc_type alarmSrc,
  // Calibration status pin and summary output
  input wire logic calStatusSelAlarm,
  input wire logic calStatusIn,
  output logic calibrationStatusPin,
  output logic alarmSummary
);
  import alarm_status_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] rdData;
    logic summary;
    logic calPin;
    logic linkEnPrev;
  } state_type;

  state_type state_r;
  state_type state_nxt;
  logic [FLAG_W-1:0] flagSet;
  logic [FLAG_W-1:0] flagClr;
  logic [FLAG_W-1:0] alarmFlags;
  logic [MAX_LANES-1:0] laneClr;
  logic [MAX_LANES-1:0] laneFlags;
  logic linkStartup;

  function automatic logic writesTo(input regReq_type req, input logic [ADDR_W-1:0] a);
    return req.wrEn && (req.addr == a);
  endfunction : writesTo

  // ************************************************************
  // Alarm sources
  // ************************************************************
  // Undefined-while-disabled flags other than the link flag (bit 3) are still driven by the raw sources
  always_comb begin
    linkStartup = alarmSrc.serialLinkEnable && !state_r.linkEnPrev;
    flagSet = '0;
    flagSet[FIFO_FLAG_BIT] = |alarmSrc.laneFifoErr;
    flagSet[PLL_FLAG_BIT] = !alarmSrc.pllLocked;
    if (alarmSrc.serialLinkEnable) begin
      if (alarmSrc.mode64b66b) begin
        flagSet[LINK_FLAG_BIT] = linkStartup || alarmSrc.linkRealignEvent;
      end else begin
        flagSet[LINK_FLAG_BIT] = !alarmSrc.dataTransmitState;
      end
    end
    flagSet[REALIGN_FLAG_BIT] = alarmSrc.clockRealignEvent;
    flagSet[CLK_FLAG_BIT] = alarmSrc.dividerPhaseAB != alarmSrc.dividerPhaseCD;
    flagClr = '0;
    if (writesTo(regReq, ALARM_FLAGS_ADDR)) begin
      flagClr = regReq.wrData[FLAG_W-1:0];
    end
    laneClr = '0;
    if (writesTo(regReq, PER_LANE_FIFO_ERRORS_ADDR)) begin
      laneClr = regReq.wrData;
    end
    if (writesTo(regReq, ALARM_FLAGS_ADDR) && regReq.wrData[FIFO_FLAG_BIT]) begin
      laneClr = LANES_ALL;
    end
  end

  alarm_sticky_bank #(
    .W(FLAG_W),
    .RESET_VAL(FLAGS_RESET)
  ) u_flags (
    .mclk(mclk),
    .rst_n(rst_n),
    .setReq(flagSet),
    .clrReq(flagClr),
    .flags(alarmFlags)
  );

  // Lane record has no reserved bits, so it shares the same bank logic
  alarm_sticky_bank #(
    .W(MAX_LANES),
    .RESET_VAL(LANES_RESET)
  ) u_lanes (
    .mclk(mclk),
    .rst_n(rst_n),
    .setReq(alarmSrc.laneFifoErr),
    .clrReq(laneClr),
    .flags(laneFlags)
  );

  // ************************************************************
  // Registers and outputs
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    state_nxt.linkEnPrev = alarmSrc.serialLinkEnable;
    if (writesTo(regReq, ALARM_SOURCE_MASK_ADDR)) begin
      state_nxt.mask = regReq.wrData;
    end
    // Summary lags the flags by one cycle so the pin stays a clean flop output
    state_nxt.summary = |(alarmFlags & ~state_r.mask[FLAG_W-1:0] & SOURCE_BITS);
    state_nxt.calPin = calStatusSelAlarm ? state_r.summary : calStatusIn;
    if (regReq.rdEn) begin
      case (regReq.addr)
        ALARM_SUMMARY_ADDR: begin
          state_nxt.rdData = '0;
          state_nxt.rdData[SUMMARY_BIT] = state_r.summary;
        end
        ALARM_FLAGS_ADDR: begin
          state_nxt.rdData = {{(DATA_W-FLAG_W){1'b0}}, alarmFlags};
        end
        ALARM_SOURCE_MASK_ADDR: begin
          state_nxt.rdData = state_r.mask;
        end
        PER_LANE_FIFO_ERRORS_ADDR: begin
          state_nxt.rdData = laneFlags;
        end
        default: begin
          state_nxt.rdData = '0;
        end
      endcase
    end
    if (!rst_n) begin
      state_nxt.mask = MASK_RESET;
      state_nxt.rdData = '0;
      state_nxt.summary = 1'b0;
      state_nxt.calPin = 1'b0;
      state_nxt.linkEnPrev = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    state_r <= state_nxt;
  end

  assign regRdData = state_r.rdData;
  assign calibrationStatusPin = state_r.calPin;
  assign alarmSummary = state_r.summary;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence clearFifoWrite;
    writesTo(regReq, ALARM_FLAGS_ADDR) && regReq.wrData[FIFO_FLAG_BIT] && !(|alarmSrc.laneFifoErr);
  endsequence

  summary_masked_a: assert property (
    ##1 (alarmSummary == $past(|(alarmFlags & ~state_r.mask[FLAG_W-1:0] & SOURCE_BITS))))
    else $error("Summary does not match unmasked flags");

  cal_pin_route_a: assert property (
    calStatusSelAlarm |=> (calibrationStatusPin == $past(alarmSummary)))
    else $error("Calibration pin does not carry the summary");

  fifo_flag_set_a: assert property (
    (|alarmSrc.laneFifoErr) |=> alarmFlags[FIFO_FLAG_BIT])
    else $error("Lane FIFO error did not set its flag");

  lane_record_a: assert property (
    (|alarmSrc.laneFifoErr) |=> ((laneFlags & $past(alarmSrc.laneFifoErr)) == $past(alarmSrc.laneFifoErr)))
    else $error("Lane record missed an erroring lane");

  pll_flag_set_a: assert property (
    !alarmSrc.pllLocked |=> alarmFlags[PLL_FLAG_BIT])
    else $error("PLL unlock did not set its flag");

  link8b_flag_a: assert property (
    (alarmSrc.serialLinkEnable && !alarmSrc.mode64b66b && !alarmSrc.dataTransmitState)
    |=> alarmFlags[LINK_FLAG_BIT])
    else $error("Link outside data state did not set its flag");

  link64b_flag_a: assert property (
    (alarmSrc.serialLinkEnable && alarmSrc.mode64b66b && (linkStartup || alarmSrc.linkRealignEvent))
    |=> alarmFlags[LINK_FLAG_BIT])
    else $error("Link start-up or realignment did not set its flag");

  realign_flag_a: assert property (
    alarmSrc.clockRealignEvent |=> alarmFlags[REALIGN_FLAG_BIT])
    else $error("Clock realignment did not set its flag");

  divider_flag_a: assert property (
    (alarmSrc.dividerPhaseAB != alarmSrc.dividerPhaseCD) |=> alarmFlags[CLK_FLAG_BIT])
    else $error("Divider mismatch did not set its flag");

  reset_values_a: assert property (disable iff (1'b0)
    !rst_n |=> (alarmFlags == FLAGS_RESET && state_r.mask == MASK_RESET && !alarmSummary))
    else $error("Reset values wrong");

  lane_clear_a: assert property (
    clearFifoWrite |=> (laneFlags == '0))
    else $error("FIFO flag clear left lane record bits");

endmodule : adc_alarm_status_unit

// >>> rtl/alarm_status_pkg.sv
// Shared constants and carriers for the converter alarm collection logic.
// Assumes one digital clock domain and a register port from the serial decoder.
package alarm_status_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ALARM_SUMMARY_ADDR = 12'h2c0;
  localparam logic [ADDR_W-1:0] ALARM_FLAGS_ADDR = 12'h2c1;
  localparam logic [ADDR_W-1:0] ALARM_SOURCE_MASK_ADDR = 12'h2c2;
  localparam logic [ADDR_W-1:0] PER_LANE_FIFO_ERRORS_ADDR = 12'h2c4;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int SUMMARY_BIT = 0;
  localparam int FIFO_FLAG_BIT = 5;
  localparam int PLL_FLAG_BIT = 4;
  localparam int LINK_FLAG_BIT = 3;
  localparam int REALIGN_FLAG_BIT = 2;
  localparam int RSVD_FLAG_BIT = 1;
  localparam int CLK_FLAG_BIT = 0;
  localparam int FLAG_W = 6;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h3f;
  localparam logic [DATA_W-1:0] MASK_RESET = 8'h3f;
  localparam logic [FLAG_W-1:0] SOURCE_BITS = 6'h3d;
  localparam int MAX_LANES = 8;
  localparam logic [MAX_LANES-1:0] LANES_RESET = 8'hff;
  localparam logic [MAX_LANES-1:0] LANES_ALL = 8'hff;
  localparam int DIV_W = 4;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } regReq_type;

  typedef struct packed {
    logic [MAX_LANES-1:0] laneFifoErr;
    logic pllLocked;
    logic serialLinkEnable;
    logic mode64b66b;
    logic dataTransmitState;
    logic linkRealignEvent;
    logic clockRealignEvent;
    logic [DIV_W-1:0] dividerPhaseAB;
    logic [DIV_W-1:0] dividerPhaseCD;
  } alarmSrc_type;

endpackage : alarm_status_pkg

// >>> rtl/alarm_sticky_bank.sv
// Bank of sticky flags: hardware sets, software clears by writing one.
// Set and clear requests arrive on the same clock as the bank.
`timescale 1ns/1ps
module alarm_sticky_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Requests
  input wire logic [W-1:0] setReq,
  input wire logic [W-1:0] clrReq,
  // Flags
  output logic [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } bank_type;

  bank_type bank_r;
  bank_type bank_nxt;

  always_comb begin
    bank_nxt = bank_r;
    // A condition still present during a clearing write keeps the flag up
    bank_nxt.flags = (bank_r.flags & ~clrReq) | setReq;
    if (!rst_n) begin
      bank_nxt.flags = RESET_VAL;
    end
  end

  always_ff @(posedge mclk) begin
    bank_r <= bank_nxt;
  end

  assign flags = bank_r.flags;

  // ************************************************************
  // Checks
  // ************************************************************
  set_wins_a: assert property (@(posedge mclk) disable iff (!rst_n)
    |(setReq & clrReq) |=> ((flags & $past(setReq & clrReq)) == $past(setReq & clrReq)))
    else $error("Set lost against a clearing write");

  clear_holds_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (setReq == '0) |=> (flags == ($past(flags) & ~$past(clrReq))))
    else $error("Flag changed without a set or a clear");

endmodule : alarm_sticky_bank

// >>> bench/adc_alarm_status_unit_test.sv
// Self-checking bench for the alarm status unit: register port, sources, mask, pin.
// Assumes the package and design files are compiled first; sources drive synchronously.
`timescale 1ns/1ps
module adc_alarm_status_unit_test;
  import alarm_status_pkg::*;
  logic mclk, rst_n, calStatusSelAlarm, calStatusIn, calibrationStatusPin, alarmSummary;
  logic rdLate;
  logic [15:0] seed;
  logic [7:0] lane;
  logic [7:0] expQ[$];
  logic [DATA_W-1:0] regRdData;
  regReq_type regReq;
  alarmSrc_type src;
  int miscompares = 0;
  int nChecks = 0;
  int bitTab[7] = '{5, 4, 3, 2, 0, 3, 3};

  adc_alarm_status_unit dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .regReq(regReq),
    .regRdData(regRdData),
    .alarmSrc(src),
    .calStatusSelAlarm(calStatusSelAlarm),
    .calStatusIn(calStatusIn),
    .calibrationStatusPin(calibrationStatusPin),
    .alarmSummary(alarmSummary)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrapUp();
    if (miscompares == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrapUp

  // Idle sources: dividers equal but wandering, so a stuck compare shows up
  task automatic quiet(input logic m64);
    src = '0;
    src.pllLocked = 1'b1;
    src.serialLinkEnable = 1'b1;
    src.dataTransmitState = 1'b1;
    src.mode64b66b = m64;
    src.dividerPhaseAB = seed[3:0];
    src.dividerPhaseCD = seed[3:0];
  endtask : quiet

  task automatic regWr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge mclk);
    regReq.wrEn = 1'b1;
    regReq.addr = a;
    regReq.wrData = d;
    @(negedge mclk);
    regReq.wrEn = 1'b0;
  endtask : regWr

  task automatic regRd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(negedge mclk);
    regReq.rdEn = 1'b1;
    regReq.addr = a;
    expQ.push_back(exp);
    @(negedge mclk);
    regReq.rdEn = 1'b0;
  endtask : regRd

  // Start-up case drops the enable first so the next cycle is a rising edge
  task automatic pulse(input int i, input logic [7:0] ln);
    @(negedge mclk);
    case (i)
      0: src.laneFifoErr = ln;
      1: src.pllLocked = 1'b0;
      2: src.dataTransmitState = 1'b0;
      3: src.clockRealignEvent = 1'b1;
      4: src.dividerPhaseCD = ~src.dividerPhaseAB;
      5: {src.mode64b66b, src.linkRealignEvent} = 2'b11;
      default: {src.mode64b66b, src.serialLinkEnable} = 2'b10;
    endcase
    @(negedge mclk);
    quiet(i >= 5);
    @(negedge mclk);
    quiet(1'b0);
  endtask : pulse

  // ************************************************************
  // Read result watcher
  // ************************************************************
  always @(posedge mclk) rdLate <= regReq.rdEn;
  always @(negedge mclk) begin
    if (rdLate === 1'b1) begin
      if (expQ.size() == 0) begin
        check("readQueue", 8'h01, 8'h00);
      end else begin
        check("regRdData", regRdData, expQ.pop_front());
      end
    end
  end

  initial begin
    #20000;
    miscompares++;
    wrapUp();
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    regReq = '0;
    calStatusSelAlarm = 1'b0;
    calStatusIn = 1'b0;
    seed = 16'h5db0;
    quiet(1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    regRd(ALARM_FLAGS_ADDR, 8'h3f);
    regRd(ALARM_SOURCE_MASK_ADDR, 8'h3f);
    regRd(ALARM_SUMMARY_ADDR, 8'h00);
    regRd(PER_LANE_FIFO_ERRORS_ADDR, 8'hff);
    regRd(12'h2c3, 8'h00);
    regWr(ALARM_FLAGS_ADDR, 8'h00);
    regWr(ALARM_SUMMARY_ADDR, 8'hff);
    regRd(ALARM_FLAGS_ADDR, 8'h3f);
    regWr(ALARM_FLAGS_ADDR, 8'hff);
    regRd(ALARM_FLAGS_ADDR, 8'h00);
    regRd(PER_LANE_FIFO_ERRORS_ADDR, 8'h00);
    regWr(ALARM_SOURCE_MASK_ADDR, 8'h00);
    regRd(ALARM_SUMMARY_ADDR, 8'h00);
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      lane = 8'h01 << seed[2:0];
      pulse(i, lane);
      repeat (2) @(negedge mclk);
      check("alarmSummary", {7'h0, alarmSummary}, 8'h01);
      regRd(ALARM_FLAGS_ADDR, 8'h01 << bitTab[i]);
      regRd(ALARM_SUMMARY_ADDR, 8'h01);
      if (i == 0) begin
        regRd(PER_LANE_FIFO_ERRORS_ADDR, lane);
        regWr(PER_LANE_FIFO_ERRORS_ADDR, lane);
        regRd(PER_LANE_FIFO_ERRORS_ADDR, 8'h00);
      end
      regWr(ALARM_SOURCE_MASK_ADDR, 8'h01 << bitTab[i]);
      repeat (2) @(negedge mclk);
      check("alarmSummary", {7'h0, alarmSummary}, 8'h00);
      regWr(ALARM_SOURCE_MASK_ADDR, 8'h00);
      regWr(ALARM_FLAGS_ADDR, 8'h01 << bitTab[i]);
      regRd(ALARM_FLAGS_ADDR, 8'h00);
    end
    // Lock loss lasts only the clearing cycle, so a lost set would read back as zero
    @(negedge mclk);
    regReq.wrEn = 1'b1;
    regReq.addr = ALARM_FLAGS_ADDR;
    regReq.wrData = 8'h10;
    src.pllLocked = 1'b0;
    @(negedge mclk);
    regReq.wrEn = 1'b0;
    src.pllLocked = 1'b1;
    regRd(ALARM_FLAGS_ADDR, 8'h10);
    seed = lfsr(seed);
    calStatusIn = seed[0];
    repeat (2) @(negedge mclk);
    check("calibrationStatusPin", {7'h0, calibrationStatusPin}, {7'h0, seed[0]});
    // Normal status held low so a pin stuck on it cannot pass as the summary
    calStatusIn = 1'b0;
    calStatusSelAlarm = 1'b1;
    repeat (2) @(negedge mclk);
    check("calibrationStatusPin", {7'h0, calibrationStatusPin}, 8'h01);
    regWr(ALARM_FLAGS_ADDR, 8'h10);
    repeat (2) @(negedge mclk);
    check("calibrationStatusPin", {7'h0, calibrationStatusPin}, 8'h00);
    quiet(1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    regRd(ALARM_FLAGS_ADDR, 8'h3f);
    repeat (2) @(negedge mclk);
    wrapUp();
  end
endmodule : adc_alarm_status_unit_test
